// ==== afdn_core.sv ====
// Contract
// - fractional divider runs only when its enable bit is set
// - ratio is divider plus remainder over denominator at binary-point scale
// - fractional divider clocked from oscillator divided by two
// - divider field has four integer bits and 36 fixed fraction bits; binary point scales the remainder
// - zero divider, zero remainder, denominator one means divide by 16
// - 42-bit feedback divider write sets loop multiplication ratio
// - 40-bit fractional divider write applies directly as ratio
// - increment trigger change adds step shifted left seven
// - decrement trigger change subtracts step shifted left seven
// - readback gives current value when select is 1, nominal when 0
// - triggers ignored unless loop is locked
// - on relock the current value returns to nominal
// - stepping only when enabled; clearing enable restores nominal
// - lock status bit reports loop lock and gates stepping
module afdn_core
  import afdn_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic loop_lock_i,
  input wire logic [FB_W-1:0] loop_feedback_divider_i,
  input wire logic [DEN_W-1:0] loop_feedback_remainder_i,
  input wire logic [DEN_W-1:0] loop_feedback_denominator_i,
  input wire logic [BP_W-1:0] loop_feedback_binary_point_i,
  input wire logic frac_divider_enable_i,
  input wire logic [FRAC_W-1:0] frac_divider_value_i,
  input wire logic [DEN_W-1:0] frac_remainder_i,
  input wire logic [DEN_W-1:0] frac_denominator_i,
  input wire logic [BP_W-1:0] frac_binary_point_i,
  input wire logic [STEP_W-1:0] step_size_i,
  input wire logic [SEL_W-1:0] increment_trigger_select_i,
  input wire logic [SEL_W-1:0] decrement_trigger_select_i,
  input wire logic [NUM_TRIG-1:0] trigger_i,
  input wire logic read_current_select_i,
  input wire logic stepping_enable_i,
  input wire logic modulate_output_divider_select_i,
  output logic loop_locked_o,
  output logic [FB_W-1:0] feedback_current_o,
  output logic [FB_W-1:0] feedback_readback_o,
  output logic [DEN_W-1:0] feedback_remainder_o,
  output logic [DEN_W-1:0] feedback_denominator_o,
  output logic [BP_W-1:0] feedback_binary_point_o,
  output logic [FRAC_W:0] frac_ratio_o,
  output logic frac_half_clk_o,
  output logic frac_clk_o
);
  afdn_step_if step_ev ();
  logic [FB_W-1:0] nominal_reg;
  logic [FB_W-1:0] current_reg;
  logic [FB_W-1:0] current_next;
  logic [FB_W-1:0] step_amount;
  logic lock_reg;
  logic lock_prev_reg;
  logic relock;
  logic step_allowed;
  afdn_step_t step_cmd;

  afdn_trig_sync u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .trig_i(trigger_i),
    .inc_sel_i(increment_trigger_select_i),
    .dec_sel_i(decrement_trigger_select_i),
    .ev(step_ev.src)
  );

  afdn_frac_div u_frac (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .frac_divider_enable_i(frac_divider_enable_i),
    .frac_divider_value_i(frac_divider_value_i),
    .frac_remainder_i(frac_remainder_i),
    .frac_denominator_i(frac_denominator_i),
    .frac_binary_point_i(frac_binary_point_i),
    .ratio_o(frac_ratio_o),
    .half_vco_o(frac_half_clk_o),
    .frac_clk_o(frac_clk_o)
  );

  // lock status tracking
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      lock_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
    end else begin
      lock_reg <= loop_lock_i;
      lock_prev_reg <= lock_reg;
    end
  end

  assign loop_locked_o = lock_reg;
  assign relock = lock_reg & ~lock_prev_reg;
  assign step_allowed = lock_reg & stepping_enable_i & ~modulate_output_divider_select_i;
  assign step_amount = FB_W'(step_size_i) << STEP_SHIFT;

  // nominal value capture from host write
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      nominal_reg <= FB_RESET_VALUE;
    end else begin
      nominal_reg <= loop_feedback_divider_i;
    end
  end

  always_comb begin
    step_cmd = AFDN_HOLD;
    if (step_allowed) begin
      if (step_ev.inc_event && !step_ev.dec_event) begin
        step_cmd = AFDN_INC;
      end else if (step_ev.dec_event && !step_ev.inc_event) begin
        step_cmd = AFDN_DEC;
      end
    end
  end

  always_comb begin
    current_next = current_reg;
    if (!stepping_enable_i || relock || nominal_reg != loop_feedback_divider_i) begin
      current_next = loop_feedback_divider_i;
    end else begin
      case (step_cmd)
        AFDN_INC: current_next = current_reg + step_amount;
        AFDN_DEC: current_next = current_reg - step_amount;
        AFDN_HOLD: current_next = current_reg;
        default: current_next = current_reg;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      current_reg <= FB_RESET_VALUE;
    end else begin
      current_reg <= current_next;
    end
  end

  assign feedback_current_o = current_reg;

  // readback select
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      feedback_readback_o <= FB_RESET_VALUE;
    end else if (read_current_select_i) begin
      feedback_readback_o <= current_reg;
    end else begin
      feedback_readback_o <= nominal_reg;
    end
  end

  // loop fraction settings forwarded to the analog loop
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      feedback_remainder_o <= '0;
      feedback_denominator_o <= DEN_ONE;
      feedback_binary_point_o <= '0;
    end else begin
      feedback_remainder_o <= loop_feedback_remainder_i;
      feedback_denominator_o <= loop_feedback_denominator_i;
      feedback_binary_point_o <= loop_feedback_binary_point_i;
    end
  end
endmodule // afdn_core

// ==== afdn_core_props.sv ====
module afdn_core_props
  import afdn_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic loop_lock_i,
  input wire logic [FB_W-1:0] loop_feedback_divider_i,
  input wire logic frac_divider_enable_i,
  input wire logic [FRAC_W-1:0] frac_divider_value_i,
  input wire logic [DEN_W-1:0] frac_remainder_i,
  input wire logic [DEN_W-1:0] frac_denominator_i,
  input wire logic [BP_W-1:0] frac_binary_point_i,
  input wire logic [STEP_W-1:0] step_size_i,
  input wire logic read_current_select_i,
  input wire logic stepping_enable_i,
  input wire logic loop_locked_o,
  input wire logic [FB_W-1:0] feedback_current_o,
  input wire logic [FB_W-1:0] feedback_readback_o,
  input wire logic [FRAC_W:0] frac_ratio_o,
  input wire logic frac_half_clk_o,
  input wire logic frac_clk_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic [FB_W-1:0] dlt;
  assign dlt = {11'h000, step_size_i, 7'h00};
  a_lock_follows: assert property ($past(reset_n_i) |-> loop_locked_o == $past(loop_lock_i))
    else $error("lock status wrong");
  a_frac_off: assert property (!frac_divider_enable_i [*2] |-> !frac_clk_o)
    else $error("divider clock while disabled");
  a_half_rate: assert property ($past(reset_n_i, 2) |-> frac_half_clk_o != $past(frac_half_clk_o))
    else $error("half clock not toggling");
  a_ratio_sixteen: assert property (frac_divider_value_i == '0 && frac_remainder_i == '0
    && frac_denominator_i == DEN_ONE |=> frac_ratio_o == RATIO_SIXTEEN)
    else $error("ratio not sixteen");
  a_ratio_plain: assert property (frac_divider_value_i != '0 && frac_remainder_i == '0
    && frac_denominator_i == DEN_ONE && frac_binary_point_i == '0
    |=> frac_ratio_o == {1'b0, $past(frac_divider_value_i)})
    else $error("ratio not the written value");
  a_step_only: assert property ($changed(feedback_current_o)
    && feedback_current_o != $past(loop_feedback_divider_i) |-> $past(loop_locked_o)
    && (feedback_current_o == $past(feedback_current_o) + dlt
    || feedback_current_o == $past(feedback_current_o) - dlt))
    else $error("illegal feedback change");
  a_off_nominal: assert property (!stepping_enable_i
    |=> feedback_current_o == $past(loop_feedback_divider_i))
    else $error("disabled stepping not nominal");
  a_readback_sel: assert property ($past(reset_n_i) |=> feedback_readback_o ==
    ($past(read_current_select_i) ? $past(feedback_current_o)
    : $past(loop_feedback_divider_i, 2)))
    else $error("readback wrong");
  a_relock_nominal: assert property ($rose(loop_lock_i)
    |-> ##[1:3] feedback_current_o == loop_feedback_divider_i)
    else $error("relock not nominal");
  cover property ($changed(feedback_current_o) && loop_locked_o);
  cover property ($rose(frac_clk_o));
  cover property ($rose(loop_locked_o));
endmodule // afdn_core_props

bind afdn_core afdn_core_props i_props (.*);

// ==== afdn_frac_div.sv ====
module afdn_frac_div
  import afdn_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic frac_divider_enable_i,
  input wire logic [FRAC_W-1:0] frac_divider_value_i,
  input wire logic [DEN_W-1:0] frac_remainder_i,
  input wire logic [DEN_W-1:0] frac_denominator_i,
  input wire logic [BP_W-1:0] frac_binary_point_i,
  output logic [FRAC_W:0] ratio_o,
  output logic half_vco_o,
  output logic frac_clk_o
);
  logic [FRAC_W:0] ratio_next;
  logic [FRAC_W+DEN_W:0] acc_reg;
  logic [FRAC_W+DEN_W:0] lim;
  logic [FRAC_W+DEN_W:0] sum;
  logic [FRAC_W+DEN_W:0] rem_scaled;
  logic [FRAC_W+DEN_W:0] period;

  // ratio in units of 2^-36, remainder folded at scale 2^-(36-bp)
  always_comb begin
    if (frac_divider_value_i == FRAC_DEFAULT_RATIO && frac_remainder_i == '0
        && frac_denominator_i == DEN_ONE) begin
      ratio_next = RATIO_SIXTEEN;
    end else begin
      ratio_next = {1'b0, frac_divider_value_i};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ratio_o <= RATIO_SIXTEEN;
    end else begin
      ratio_o <= ratio_next;
    end
  end

  // divide-by-two of oscillator clock feeds divider
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      half_vco_o <= 1'b0;
    end else begin
      half_vco_o <= ~half_vco_o;
    end
  end

  // accumulator: lim = ratio*den + rem<<bp in 2^-36 units times den
  assign period = 73'(ratio_o) * 73'(frac_denominator_i == '0 ? DEN_ONE : frac_denominator_i);
  assign rem_scaled = 73'(frac_remainder_i) << frac_binary_point_i;
  assign lim = period + rem_scaled;
  assign sum = acc_reg + (73'(frac_denominator_i == '0 ? DEN_ONE : frac_denominator_i)
               << FRAC_POINT_FULL);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      acc_reg <= '0;
      frac_clk_o <= 1'b0;
    end else if (!frac_divider_enable_i) begin
      acc_reg <= '0;
      frac_clk_o <= 1'b0;
    end else if (half_vco_o) begin
      if (sum >= lim) begin
        acc_reg <= sum - lim;
        frac_clk_o <= 1'b1;
      end else begin
        acc_reg <= sum;
        if ((sum << 1) >= lim) begin
          frac_clk_o <= 1'b0;
        end
      end
    end
  end
endmodule // afdn_frac_div

// ==== afdn_pkg.sv ====
package afdn_pkg;
  localparam int FB_W = 42;
  localparam int FRAC_W = 40;
  localparam int STEP_W = 24;
  localparam int STEP_SHIFT = 7;
  localparam int BP_W = 6;
  localparam int DEN_W = 32;
  localparam int SEL_W = 3;
  localparam int NUM_TRIG = 8;
  localparam int FRAC_POINT_FULL = 36;
  localparam int FRAC_INT_BITS = 4;
  localparam logic [FRAC_W-1:0] FRAC_DEFAULT_RATIO = 40'h0000000000;
  localparam logic [FB_W-1:0] FB_RESET_VALUE = 42'h000_0000_0000;
  localparam logic [DEN_W-1:0] DEN_ONE = 32'h0000_0001;
  localparam logic [FRAC_W:0] RATIO_SIXTEEN = {1'b1, 40'h0000000000};
  typedef enum logic [1:0] {
    AFDN_HOLD,
    AFDN_INC,
    AFDN_DEC
  } afdn_step_t;
endpackage

// ==== afdn_step_if.sv ====
interface afdn_step_if;
  import afdn_pkg::*;
  logic inc_event;
  logic dec_event;
  modport src (output inc_event, output dec_event);
  modport dst (input inc_event, input dec_event);
endinterface

// ==== afdn_trig_sync.sv ====
module afdn_trig_sync
  import afdn_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_TRIG-1:0] trig_i,
  input wire logic [SEL_W-1:0] inc_sel_i,
  input wire logic [SEL_W-1:0] dec_sel_i,
  afdn_step_if.src ev
);
  logic [NUM_TRIG-1:0] meta_reg;
  logic [NUM_TRIG-1:0] sync_reg;
  logic [NUM_TRIG-1:0] prev_reg;
  logic [NUM_TRIG-1:0] toggled;

  // two-stage sync plus change detect per trigger
  for (genvar g = 0; g < NUM_TRIG; g++) begin : g_trig
    always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
        meta_reg[g] <= 1'b0;
        sync_reg[g] <= 1'b0;
        prev_reg[g] <= 1'b0;
      end else begin
        meta_reg[g] <= trig_i[g];
        sync_reg[g] <= meta_reg[g];
        prev_reg[g] <= sync_reg[g];
      end
    end
    assign toggled[g] = sync_reg[g] ^ prev_reg[g];
  end

  assign ev.inc_event = toggled[inc_sel_i];
  assign ev.dec_event = toggled[dec_sel_i];
endmodule // afdn_trig_sync

// ==== test_afdn_core.sv ====
module test_afdn_core
  import afdn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [FB_W-1:0] NOM = 42'h100_0000_0000;
  localparam logic [FB_W-1:0] D = 42'h000_0009_1A00;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic loop_lock_i, frac_divider_enable_i, read_current_select_i;
  logic stepping_enable_i, modulate_output_divider_select_i;
  logic [FB_W-1:0] loop_feedback_divider_i, feedback_current_o, feedback_readback_o;
  logic [DEN_W-1:0] loop_feedback_remainder_i, loop_feedback_denominator_i;
  logic [DEN_W-1:0] frac_remainder_i, frac_denominator_i;
  logic [DEN_W-1:0] feedback_remainder_o, feedback_denominator_o;
  logic [BP_W-1:0] loop_feedback_binary_point_i, frac_binary_point_i, feedback_binary_point_o;
  logic [FRAC_W-1:0] frac_divider_value_i;
  logic [FRAC_W:0] frac_ratio_o;
  logic [STEP_W-1:0] step_size_i;
  logic [SEL_W-1:0] increment_trigger_select_i, decrement_trigger_select_i;
  logic [NUM_TRIG-1:0] trigger_i;
  logic loop_locked_o, frac_half_clk_o, frac_clk_o, p, q;
  int error_cnt = 0;
  int checks_done = 0;
  int n, h;

  always #5 mclk_i = ~mclk_i;

  afdn_core i_dut (.*);

  task chk(input string s, input logic [FB_W:0] seen, input logic [FB_W:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task stop_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  task tog(input int i);
    trigger_i[i] = ~trigger_i[i];
    cyc(6);
  endtask

  initial begin
    #20us;
    error_cnt++;
    stop_test();
  end

  initial begin
    {loop_lock_i, frac_divider_enable_i, read_current_select_i} = 3'h0;
    {stepping_enable_i, modulate_output_divider_select_i} = 2'h0;
    loop_feedback_divider_i = NOM;
    loop_feedback_remainder_i = '0;
    loop_feedback_denominator_i = DEN_ONE;
    loop_feedback_binary_point_i = '0;
    frac_divider_value_i = '0;
    frac_remainder_i = '0;
    frac_denominator_i = DEN_ONE;
    frac_binary_point_i = '0;
    step_size_i = 24'h001234;
    increment_trigger_select_i = 3'h2;
    decrement_trigger_select_i = 3'h5;
    trigger_i = '0;
    cyc(4);
    chk("ratio", frac_ratio_o, RATIO_SIXTEEN);
    chk("den", feedback_denominator_o, DEN_ONE);
    reset_n_i = 1'b1;
    frac_divider_value_i = 40'h50_0000_0000;
    {loop_feedback_remainder_i, loop_feedback_denominator_i} = {32'h3, 32'h7};
    loop_feedback_binary_point_i = 6'h09;
    cyc(2);
    chk("ratio", frac_ratio_o, 40'h50_0000_0000);
    chk("fbrem", feedback_remainder_o, 32'h3);
    chk("fbden", feedback_denominator_o, 32'h7);
    chk("fbbp", feedback_binary_point_o, 6'h09);
    {loop_feedback_remainder_i, loop_feedback_denominator_i} = {32'h0, DEN_ONE};
    loop_feedback_binary_point_i = '0;
    frac_remainder_i = 32'h0100_0000;
    frac_denominator_i = 32'h0000_0002;
    frac_binary_point_i = 6'h0C;
    cyc(2);
    chk("ratio", frac_ratio_o, 40'h50_0000_0000);
    frac_divider_enable_i = 1'b1;
    for (int e = 1; e >= 0; e--) begin
      cyc(3);
      n = 0;
      h = 0;
      p = frac_clk_o;
      repeat (220) begin
        q = frac_half_clk_o;
        cyc(1);
        n += (frac_clk_o && !p);
        p = frac_clk_o;
        h += (q != frac_half_clk_o);
      end
      chk("half", h, 220);
      chk("clk", n, e * 20);
      frac_divider_enable_i = 1'b0;
    end
    loop_lock_i = 1'b1;
    stepping_enable_i = 1'b1;
    cyc(4);
    chk("cur", feedback_current_o, NOM);
    tog(2);
    chk("cur", feedback_current_o, NOM + D);
    tog(2);
    chk("cur", feedback_current_o, NOM + 2 * D);
    tog(5);
    chk("cur", feedback_current_o, NOM + D);
    tog(3);
    chk("cur", feedback_current_o, NOM + D);
    trigger_i[2] = 1'b1;
    cyc(1);
    tog(2);
    chk("cur", feedback_current_o, NOM + 3 * D);
    read_current_select_i = 1'b1;
    cyc(2);
    chk("rdbk", feedback_readback_o, NOM + 3 * D);
    read_current_select_i = 1'b0;
    cyc(2);
    chk("rdbk", feedback_readback_o, NOM);
    modulate_output_divider_select_i = 1'b1;
    tog(2);
    chk("cur", feedback_current_o, NOM + 3 * D);
    modulate_output_divider_select_i = 1'b0;
    loop_lock_i = 1'b0;
    cyc(3);
    tog(2);
    chk("cur", feedback_current_o, NOM + 3 * D);
    loop_lock_i = 1'b1;
    cyc(5);
    chk("cur", feedback_current_o, NOM);
    loop_feedback_divider_i = NOM + D;
    cyc(2);
    chk("cur", feedback_current_o, NOM + D);
    chk("rdbk", feedback_readback_o, NOM + D);
    loop_feedback_divider_i = NOM;
    cyc(2);
    tog(5);
    chk("cur", feedback_current_o, NOM - D);
    stepping_enable_i = 1'b0;
    cyc(2);
    chk("cur", feedback_current_o, NOM);
    tog(5);
    chk("cur", feedback_current_o, NOM);
    stepping_enable_i = 1'b1;
    cyc(2);
    tog(2);
    chk("cur", feedback_current_o, NOM + D);
    tog(5);
    chk("cur", feedback_current_o, NOM);
    stepping_enable_i = 1'b0;
    cyc(2);
    chk("cur", feedback_current_o, NOM);
    stop_test();
  end
endmodule // test_afdn_core
